// *** design/dma_hold_pkg.sv ***
// shared constants, state codes and strobe decode for the hold handover
package dma_hold_pkg;

  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // clock and latency figures
  localparam int CLK_PERIOD_NS = 100;
  localparam int ACK_MIN_CLOCKS = 1;
  localparam int ACK_MAX_CLOCKS = 3;
  localparam int ACK_MAX_MEM_CYCLES = 3;
  localparam int RELEASE_CLOCKS = 2;
  localparam logic [1:0] RELEASE_LAST = 2'(RELEASE_CLOCKS - 1);

  // reset levels of the bus lines
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // processor end: gray along idle, cycle, hold, release
  typedef enum logic [2:0] {
    C_IDLE  = 3'b000,
    C_FIRST = 3'b001,
    C_WAIT  = 3'b011,
    C_LAST  = 3'b010,
    C_HOLD  = 3'b110,
    C_REL   = 3'b111
  } cpu_state_t;

  // dma end: gray along request, own, cycle, release
  typedef enum logic [2:0] {
    D_IDLE  = 3'b000,
    D_REQ   = 3'b001,
    D_OWN   = 3'b011,
    D_FIRST = 3'b010,
    D_WAIT  = 3'b110,
    D_LAST  = 3'b111,
    D_REL   = 3'b101
  } dma_state_t;

  // memory strobes, low active: {memory_enable, data_bus_in, write}
  function automatic logic [2:0] strobes(input logic active,
                                         input logic rd,
                                         input logic we_phase);
    strobes = {~active, ~(active & rd), ~(active & ~rd & we_phase)};
  endfunction : strobes

endpackage : dma_hold_pkg

// *** design/bus_hold_if.sv ***
// shared memory bus with hold request and acknowledge
interface bus_hold_if;

  // open-collector hold request, pulled up when nobody sinks it
  logic hold_req_out;
  logic hold_req_oe;
  logic hold_req_b;
  logic bus_grab_ack;

  // processor drivers
  logic [dma_hold_pkg::ADDR_W-1:0] cpu_addr;
  logic [dma_hold_pkg::DATA_W-1:0] cpu_data;
  logic cpu_ctl_oe;
  logic cpu_data_oe;
  logic [2:0] cpu_strobes;

  // dma drivers
  logic [dma_hold_pkg::ADDR_W-1:0] dma_addr;
  logic [dma_hold_pkg::DATA_W-1:0] dma_data;
  logic dma_ctl_oe;
  logic dma_data_oe;
  logic [2:0] dma_strobes;
  logic dma_access_cycle_b;

  // memory side, driven by the bench
  logic ready;
  logic [dma_hold_pkg::DATA_W-1:0] mem_data;

  // resolved wire levels
  logic [dma_hold_pkg::ADDR_W-1:0] addr;
  logic [dma_hold_pkg::DATA_W-1:0] data;
  logic memory_enable_b;
  logic data_bus_in_b;
  logic write_enable_b;

  // pull-up wins unless the request is sunk
  assign hold_req_b = hold_req_oe ? hold_req_out : 1'b1;

  // the processor has precedence only because both never drive at once
  assign addr = cpu_ctl_oe ? cpu_addr :
                dma_ctl_oe ? dma_addr : dma_hold_pkg::ADDR_RST;
  assign data = cpu_data_oe ? cpu_data :
                dma_data_oe ? dma_data : mem_data;
  assign {memory_enable_b, data_bus_in_b, write_enable_b} =
    cpu_ctl_oe ? cpu_strobes :
    dma_ctl_oe ? dma_strobes : 3'h7;

  modport cpu (
    output cpu_addr, cpu_data, cpu_ctl_oe, cpu_data_oe, cpu_strobes,
    output bus_grab_ack,
    input hold_req_b, ready, data
  );

  modport dma (
    output dma_addr, dma_data, dma_ctl_oe, dma_data_oe, dma_strobes,
    output dma_access_cycle_b, hold_req_out, hold_req_oe,
    input hold_req_b, bus_grab_ack, ready, data
  );

endinterface : bus_hold_if

// *** design/word_buf2.sv ***
// two-entry valid/ready buffer, head word held in a flop
module word_buf2 (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [dma_hold_pkg::DATA_W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [dma_hold_pkg::DATA_W-1:0] out_data
);

  logic [dma_hold_pkg::DATA_W-1:0] d0_q, d0_d, d1_q, d1_d;
  logic v0_q, v0_d, v1_q, v1_d;
  logic push, pop;

  assign in_ready = ~v1_q;
  assign out_valid = v0_q;
  assign out_data = d0_q;
  assign push = in_valid & ~v1_q;
  assign pop = v0_q & out_ready;

  // pop shifts the tail forward first, then a push fills the free slot
  always_comb
  begin
    d0_d = d0_q;
    d1_d = d1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (pop)
    begin
      d0_d = d1_q;
      v0_d = v1_q;
      v1_d = 1'b0;
    end
    if (push)
    begin
      if (!v0_d)
      begin
        d0_d = in_data;
        v0_d = 1'b1;
      end
      else
      begin
        d1_d = in_data;
        v1_d = 1'b1;
      end
    end
  end

  // storage
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      d0_q <= dma_hold_pkg::DATA_RST;
      d1_q <= dma_hold_pkg::DATA_RST;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end
    else if (ce)
    begin
      d0_q <= d0_d;
      d1_q <= d1_d;
      v0_q <= v0_d;
      v1_q <= v1_d;
    end
  end

endmodule : word_buf2

// *** design/cpu_hold_end.sv ***
// processor end: own memory cycles, hold entry, bus float, release
module cpu_hold_end (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // shared bus
  bus_hold_if.cpu bus,
  // core memory requests
  input wire logic core_valid,
  output logic core_ready,
  input wire logic [dma_hold_pkg::ADDR_W-1:0] core_addr,
  input wire logic [dma_hold_pkg::DATA_W-1:0] core_wdata,
  input wire logic core_write,
  // core read data and hold status
  output logic core_rvalid,
  output logic [dma_hold_pkg::DATA_W-1:0] core_rdata,
  output logic hold_active
);

  dma_hold_pkg::cpu_state_t state_q, state_d;
  logic [1:0] rel_q, rel_d;
  logic [dma_hold_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [dma_hold_pkg::DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic wr_q, wr_d, ack_q, ack_d, oe_q, oe_d, doe_q, doe_d;
  logic ready_q, ready_d, rvalid_q, rvalid_d;
  logic [2:0] strb_q, strb_d;
  logic hold_pend, in_cycle;

  assign hold_pend = ~bus.hold_req_b;

  // next state; hold only enters between memory cycles
  always_comb
  begin
    state_d = state_q;
    rel_d = rel_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wr_d = wr_q;
    unique case (state_q)
      dma_hold_pkg::C_IDLE:
        if (hold_pend)
          state_d = dma_hold_pkg::C_HOLD;
        else if (core_valid)
        begin
          state_d = dma_hold_pkg::C_FIRST;
          addr_d = core_addr;
          wdata_d = core_wdata;
          wr_d = core_write;
        end
      dma_hold_pkg::C_FIRST:
        state_d = bus.ready ? dma_hold_pkg::C_LAST : dma_hold_pkg::C_WAIT;
      dma_hold_pkg::C_WAIT:
        if (bus.ready)
          state_d = dma_hold_pkg::C_LAST;
      dma_hold_pkg::C_LAST:
        // a waiting hold beats the next core cycle, bounding latency
        state_d = hold_pend ? dma_hold_pkg::C_HOLD : dma_hold_pkg::C_IDLE;
      dma_hold_pkg::C_HOLD:
        if (!hold_pend)
        begin
          state_d = dma_hold_pkg::C_REL;
          rel_d = 2'h0;
        end
      dma_hold_pkg::C_REL:
        // acknowledge stays up for the release clocks, re-requests wait
        if (rel_q == dma_hold_pkg::RELEASE_LAST)
          state_d = dma_hold_pkg::C_IDLE;
        else
          rel_d = 2'(rel_q + 2'h1);
    endcase
  end

  // registered outputs derived from the next state; read valid and read data from the current state
  always_comb
  begin
    in_cycle = (state_d == dma_hold_pkg::C_FIRST) ||
               (state_d == dma_hold_pkg::C_WAIT) ||
               (state_d == dma_hold_pkg::C_LAST);
    ack_d = (state_d == dma_hold_pkg::C_HOLD) ||
            (state_d == dma_hold_pkg::C_REL);
    oe_d = ~ack_d;
    doe_d = oe_d & in_cycle & wr_d;
    strb_d = dma_hold_pkg::strobes(in_cycle, ~wr_d,
                                   state_d != dma_hold_pkg::C_LAST);
    ready_d = (state_d == dma_hold_pkg::C_LAST);
    rvalid_d = (state_q == dma_hold_pkg::C_LAST) & ~wr_q;
    rdata_d = rvalid_d ? bus.data : rdata_q;
  end

  // state registers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_q <= dma_hold_pkg::C_IDLE;
      rel_q <= 2'h0;
      addr_q <= dma_hold_pkg::ADDR_RST;
      wdata_q <= dma_hold_pkg::DATA_RST;
      rdata_q <= dma_hold_pkg::DATA_RST;
      wr_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b1;
      doe_q <= 1'b0;
      strb_q <= 3'h7;
      ready_q <= 1'b0;
      rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      rel_q <= rel_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      wr_q <= wr_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      doe_q <= doe_d;
      strb_q <= strb_d;
      ready_q <= ready_d;
      rvalid_q <= rvalid_d;
    end
  end

  // port wiring
  assign bus.bus_grab_ack = ack_q;
  assign bus.cpu_ctl_oe = oe_q;
  assign bus.cpu_data_oe = doe_q;
  assign bus.cpu_addr = addr_q;
  assign bus.cpu_data = wdata_q;
  assign bus.cpu_strobes = strb_q;
  assign core_ready = ready_q;
  assign core_rvalid = rvalid_q;
  assign core_rdata = rdata_q;
  assign hold_active = ack_q;

endmodule : cpu_hold_end

// *** design/dma_hold_end.sv ***
// dma end: acquires the bus, runs memory cycles, hands the bus back
//
// How it works
// - request held low while bus needed
// - processor holds at next non-memory cycle
// - acknowledge within one to bounded latency
// - processor floats bus while acknowledging
// - dma drives bus while acknowledged
// - single or back-to-back transfers per grab
// - release request, processor resumes afterwards
// - release finishes before any new acquisition
// - open-collector request, changes on clock edge
// - cycles start the second edge after acknowledge
// - dma generates strobes, access, address, data
// - dma cycles copy processor cycle timing
// - wait states while memory not ready
// - no forced waits, own setup state
// - no access until acknowledge falls
module dma_hold_end (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // shared bus
  bus_hold_if.dma bus,
  // transfer requests
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic [dma_hold_pkg::ADDR_W-1:0] xfer_addr,
  input wire logic [dma_hold_pkg::DATA_W-1:0] xfer_wdata,
  input wire logic xfer_write,
  // read data stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [dma_hold_pkg::DATA_W-1:0] rd_data,
  // status
  output logic bus_owned
);

  dma_hold_pkg::dma_state_t state_q, state_d;
  logic [dma_hold_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [dma_hold_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic wr_q, wr_d;
  logic hold_oe_q, hold_oe_d;
  logic drv_q, drv_d, doe_q, doe_d;
  logic [2:0] strb_q, strb_d;
  logic acc_b_q, acc_b_d;
  logic ready_q, ready_d;
  logic in_cycle, take;
  logic can_go, can_go_last;
  logic buf_in_valid, buf_in_ready;

  // a read needs a free buffer slot before its cycle may start
  assign can_go = xfer_valid & (xfer_write | buf_in_ready);

  // at the end of a read the slot it fills is not free yet
  assign can_go_last = xfer_valid &
                       (xfer_write | (wr_q ? buf_in_ready : ~rd_valid));

  // read data lands in the buffer at the end of the last state
  assign buf_in_valid = (state_q == dma_hold_pkg::D_LAST) & ~wr_q;

  // read buffer; a stalled reader stops new reads, never drops words
  word_buf2 u_rd_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ce(ce),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(bus.data),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  // next state of the handover sequence
  always_comb
  begin
    state_d = state_q;
    take = 1'b0;
    unique case (state_q)
      dma_hold_pkg::D_IDLE:
        // a fresh request waits for the old acknowledge to fall
        if (can_go && !bus.bus_grab_ack)
          state_d = dma_hold_pkg::D_REQ;
      dma_hold_pkg::D_REQ:
        if (bus.bus_grab_ack)
          state_d = dma_hold_pkg::D_OWN;
      dma_hold_pkg::D_OWN:
        // drivers come up here, one clock before the strobes; address loads with the first state
        if (can_go)
        begin
          state_d = dma_hold_pkg::D_FIRST;
          take = 1'b1;
        end
        else
          state_d = dma_hold_pkg::D_REL;
      dma_hold_pkg::D_FIRST:
        state_d = bus.ready ? dma_hold_pkg::D_LAST :
                              dma_hold_pkg::D_WAIT;
      dma_hold_pkg::D_WAIT:
        if (bus.ready)
          state_d = dma_hold_pkg::D_LAST;
      dma_hold_pkg::D_LAST:
        // block mode chains cycles without a gap state
        if (can_go_last)
        begin
          state_d = dma_hold_pkg::D_FIRST;
          take = 1'b1;
        end
        else
          state_d = dma_hold_pkg::D_REL;
      dma_hold_pkg::D_REL:
        // no access until the processor has dropped its acknowledge
        if (!bus.bus_grab_ack)
          state_d = dma_hold_pkg::D_IDLE;
    endcase
  end

  // transfer capture on entry to the first state
  always_comb
  begin
    addr_d = take ? xfer_addr : addr_q;
    wdata_d = take ? xfer_wdata : wdata_q;
    wr_d = take ? xfer_write : wr_q;
  end

  // registered bus drive derived from the next state
  always_comb
  begin
    in_cycle = (state_d == dma_hold_pkg::D_FIRST) ||
               (state_d == dma_hold_pkg::D_WAIT) ||
               (state_d == dma_hold_pkg::D_LAST);
    // request sunk from asking until the last cycle ends
    hold_oe_d = (state_d != dma_hold_pkg::D_IDLE) &&
                (state_d != dma_hold_pkg::D_REL);
    drv_d = in_cycle || (state_d == dma_hold_pkg::D_OWN);
    doe_d = in_cycle & wr_d;
    // write strobe follows the first and wait states only
    strb_d = dma_hold_pkg::strobes(in_cycle, ~wr_d,
                                   state_d != dma_hold_pkg::D_LAST);
    acc_b_d = ~((state_d == dma_hold_pkg::D_FIRST) ||
                (state_d == dma_hold_pkg::D_WAIT));
    ready_d = take;
  end

  // state registers; reset leaves request off and drivers floated
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_q <= dma_hold_pkg::D_IDLE;
      addr_q <= dma_hold_pkg::ADDR_RST;
      wdata_q <= dma_hold_pkg::DATA_RST;
      wr_q <= 1'b0;
      hold_oe_q <= 1'b0;
      drv_q <= 1'b0;
      doe_q <= 1'b0;
      strb_q <= 3'h7;
      acc_b_q <= dma_hold_pkg::STROBE_IDLE;
      ready_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
      hold_oe_q <= hold_oe_d;
      drv_q <= drv_d;
      doe_q <= doe_d;
      strb_q <= strb_d;
      acc_b_q <= acc_b_d;
      ready_q <= ready_d;
    end
  end

  // open collector: only ever sinks the line, never drives it high
  assign bus.hold_req_out = 1'b0;
  assign bus.hold_req_oe = hold_oe_q;

  // memory bus drive
  assign bus.dma_ctl_oe = drv_q;
  assign bus.dma_data_oe = doe_q;
  assign bus.dma_addr = addr_q;
  assign bus.dma_data = wdata_q;
  assign bus.dma_strobes = strb_q;
  assign bus.dma_access_cycle_b = acc_b_q;

  // user side
  assign xfer_ready = ready_q;
  assign bus_owned = drv_q;

endmodule : dma_hold_end

// *** tb/hold_link_monitor.sv ***
// checker on the shared bus: hold handshake, grant and bus ownership
module hold_link_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // handshake and memory ready
  input wire logic hold_req_b,
  input wire logic bus_grab_ack,
  input wire logic ready,
  // drivers and strobes
  input wire logic cpu_ctl_oe,
  input wire logic cpu_data_oe,
  input wire logic dma_ctl_oe,
  input wire logic dma_data_oe,
  input wire logic dma_access_cycle_b,
  input wire logic memory_enable_b,
  input wire logic write_enable_b
);
  // worst grant wait: three clocks plus three cycles with one wait each
  localparam int ACK_LIMIT = 12;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // grant side
  a_cpu_floats:
    assert property (bus_grab_ack |-> !cpu_ctl_oe && !cpu_data_oe)
    else $error("processor drives bus during grant");
  a_grant_not_early:
    assert property ($fell(hold_req_b) |-> !bus_grab_ack)
    else $error("grant in the request cycle");
  a_grant_bound:
    assert property ($fell(hold_req_b) |-> ##[1:ACK_LIMIT] bus_grab_ack)
    else $error("grant too late");
  a_release_drop:
    assert property ($rose(hold_req_b) && bus_grab_ack |=>
      bus_grab_ack ##1 bus_grab_ack ##1 !bus_grab_ack)
    else $error("grant drop not two clocks after release");
  // requesting side
  a_dma_needs_grant:
    assert property (dma_ctl_oe || dma_data_oe |-> bus_grab_ack)
    else $error("dma drives bus without grant");
  a_req_kept:
    assert property (!hold_req_b && !bus_grab_ack |=> !hold_req_b)
    else $error("request dropped before grant");
  a_no_rerequest:
    assert property (hold_req_b && bus_grab_ack |=> hold_req_b)
    else $error("request again during release");
  a_access_owned:
    assert property (!dma_access_cycle_b |-> dma_ctl_oe && !memory_enable_b)
    else $error("access cycle outside owned memory cycle");
  a_wait_on_ready:
    assert property (!dma_access_cycle_b && !ready |=> !dma_access_cycle_b)
    else $error("dma cycle ended while memory not ready");
  a_write_data:
    assert property (!write_enable_b |->
      !memory_enable_b && (cpu_data_oe || dma_data_oe))
    else $error("write strobe without data or enable");
  a_reset_quiet:
    assert property ($rose(rst_b) |-> hold_req_b && !dma_ctl_oe)
    else $error("dma not quiet after reset");
endmodule : hold_link_monitor

// *** tb/testbench.sv ***
// bench: both hold ends on one bus, a small memory, directed scenarios
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [dma_hold_pkg::ADDR_W-1:0] addr_t;
  typedef logic [dma_hold_pkg::DATA_W-1:0] word_t;
  // stimulus, outputs, reference memory and counters
  logic ref_clk = 1'b0, rst_b = 1'b0, ce = 1'b1, slow = 1'b0;
  logic core_valid = 1'b0, core_write = 1'b0, rd_ready = 1'b1;
  logic xfer_valid = 1'b0, xfer_write = 1'b0;
  addr_t core_addr = 16'h0000, xfer_addr = 16'h0000;
  word_t core_wdata = 16'h0000, xfer_wdata = 16'h0000;
  logic core_ready, core_rvalid, hold_active, xfer_ready, rd_valid, bus_owned;
  word_t core_rdata, rd_data;
  word_t mem [16];
  word_t mem_ref [16];
  word_t exp_q [$];
  int failures = 0, n_checks = 0, cycles = 0;
  int lat_n = 0, lat_last = 0, acq_n = 0, rel_n = 0, rel_last = 0;

  bus_hold_if bus ();
  cpu_hold_end i_cpu_hold_end (.ref_clk, .rst_b, .ce, .bus(bus.cpu),
    .core_valid, .core_ready, .core_addr, .core_wdata, .core_write,
    .core_rvalid, .core_rdata, .hold_active);
  dma_hold_end i_dma_hold_end (.ref_clk, .rst_b, .ce, .bus(bus.dma),
    .xfer_valid, .xfer_ready, .xfer_addr, .xfer_wdata, .xfer_write,
    .rd_valid, .rd_ready, .rd_data, .bus_owned);
  hold_link_monitor i_hold_link_monitor (.ref_clk, .rst_b,
    .hold_req_b(bus.hold_req_b), .bus_grab_ack(bus.bus_grab_ack),
    .ready(bus.ready), .cpu_ctl_oe(bus.cpu_ctl_oe),
    .cpu_data_oe(bus.cpu_data_oe), .dma_ctl_oe(bus.dma_ctl_oe),
    .dma_data_oe(bus.dma_data_oe),
    .dma_access_cycle_b(bus.dma_access_cycle_b),
    .memory_enable_b(bus.memory_enable_b),
    .write_enable_b(bus.write_enable_b));

  always #50 ref_clk = ~ref_clk;

  // memory: registered read, one wait at most when slow
  always @(posedge ref_clk)
  begin
    bus.ready <= slow ? ~bus.ready : 1'b1;
    bus.mem_data <= mem[bus.addr[3:0]];
    if (!bus.write_enable_b)
      mem[bus.addr[3:0]] <= bus.data;
  end

  // wire timing in clocks, grab count and the hang limit
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (!bus.hold_req_b && !bus.bus_grab_ack)
      lat_n <= lat_n + 1;
    else if (lat_n != 0)
    begin
      lat_last <= lat_n;
      lat_n <= 0;
      acq_n <= acq_n + 1;
    end
    if (bus.hold_req_b && bus.bus_grab_ack)
      rel_n <= rel_n + 1;
    else if (rel_n != 0)
    begin
      rel_last <= rel_n;
      rel_n <= 0;
    end
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  // read stream drains in order against the expected queue
  always @(posedge ref_clk)
    if (rd_valid === 1'b1 && rd_ready)
      check_word("dma read", exp_q.pop_front(), rd_data);

  task automatic check_word(input string what, input word_t exp,
                            input word_t got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_flag(input string what, input logic exp,
                            input logic got);
    check_word(what, 16'(exp), 16'(got));
  endtask : check_flag

  // core access; reads compared with the reference copy
  task automatic core_op(input logic wr, input addr_t a, input word_t d);
    int n = 0;
    core_valid <= 1'b1;
    core_write <= wr;
    core_addr <= a;
    core_wdata <= d;
    if (wr)
      mem_ref[a[3:0]] = d;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (core_ready !== 1'b1 && n < 100);
    check_flag("core taken", 1'b1, core_ready);
    core_valid <= 1'b0;
    @(posedge ref_clk);
    check_flag("core answer", ~wr, core_rvalid);
    if (!wr)
      check_word("core read", mem_ref[a[3:0]], core_rdata);
  endtask : core_op

  // dma transfer; keep leaves the request up to chain the next one
  task automatic dma_op(input logic wr, input addr_t a, input word_t d,
                        input logic keep);
    int n = 0;
    xfer_valid <= 1'b1;
    xfer_write <= wr;
    xfer_addr <= a;
    xfer_wdata <= d;
    if (wr)
      mem_ref[a[3:0]] = d;
    else
      exp_q.push_back(mem_ref[a[3:0]]);
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (xfer_ready !== 1'b1 && n < 200);
    check_flag("xfer taken", 1'b1, xfer_ready);
    if (!keep)
      xfer_valid <= 1'b0;
  endtask : dma_op

  // idle levels straight out of reset
  task automatic t_reset();
    check_word("idle lines", 16'h005e, 16'({bus.hold_req_b,
      bus.bus_grab_ack, bus.memory_enable_b, bus.data_bus_in_b,
      bus.write_enable_b, bus.dma_access_cycle_b, bus_owned}));
    check_word("idle address", 16'h0000, bus.addr);
  endtask : t_reset

  // one stolen cycle with the processor idle, core reads it back
  task automatic t_single();
    @(posedge ref_clk);
    dma_op(1'b1, 16'h0004, 16'h5a3c, 1'b0);
    check_flag("hold status", 1'b1, hold_active);
    check_flag("dma owns bus", 1'b1, bus_owned);
    repeat (12) @(posedge ref_clk);
    check_word("grant latency", 16'h0001, 16'(lat_last));
    check_word("release clocks", 16'(dma_hold_pkg::RELEASE_CLOCKS + 1),
      16'(rel_last));
    core_op(1'b0, 16'h0004, 16'h0000);
  endtask : t_single

  // three chained writes must use a single grab
  task automatic t_block();
    int acq0 = acq_n;
    @(posedge ref_clk);
    dma_op(1'b1, 16'h0001, 16'h1111, 1'b1);
    dma_op(1'b1, 16'h0002, 16'h2222, 1'b1);
    dma_op(1'b1, 16'h0003, 16'h3333, 1'b0);
    repeat (8) @(posedge ref_clk);
    check_word("grabs in block", 16'h0001, 16'(acq_n - acq0));
    for (int i = 1; i < 4; i++)
      core_op(1'b0, 16'(i), 16'h0000);
  endtask : t_block

  // reads with the receiver stalled: buffer fills, no word lost
  task automatic t_read_stall();
    core_op(1'b1, 16'h0008, 16'hc0de);
    rd_ready <= 1'b0;
    fork
      begin
        dma_op(1'b0, 16'h0001, 16'h0000, 1'b1);
        dma_op(1'b0, 16'h0002, 16'h0000, 1'b1);
        dma_op(1'b0, 16'h0008, 16'h0000, 1'b0);
      end
      begin
        repeat (30) @(posedge ref_clk);
        check_flag("stalled word", 1'b1, rd_valid);
        rd_ready <= 1'b1;
      end
    join
    repeat (8) @(posedge ref_clk);
    check_word("words left", 16'h0000, 16'(exp_q.size()));
  endtask : t_read_stall

  // core and dma ask together with slow memory
  task automatic t_contend();
    slow <= 1'b1;
    @(posedge ref_clk);
    fork
      core_op(1'b0, 16'h0002, 16'h0000);
      dma_op(1'b1, 16'h0006, 16'h6e6e, 1'b0);
    join
    repeat (12) @(posedge ref_clk);
    check_flag("grant in bound", 1'b1, lat_last >= 1 &&
      lat_last <= dma_hold_pkg::ACK_MAX_CLOCKS +
      3 * dma_hold_pkg::ACK_MAX_MEM_CYCLES);
    core_op(1'b0, 16'h0006, 16'h0000);
    slow <= 1'b0;
  endtask : t_contend

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // reset, then the scenarios in turn
  initial
  begin
    bus.ready = 1'b1;
    bus.mem_data = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      mem[i] = 16'h0000;
      mem_ref[i] = 16'h0000;
    end
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_single();
    t_block();
    t_read_stall();
    t_contend();
    end_of_test();
  end
endmodule : testbench
